// [verilog/rai_indicators.sv]
// What this block does
// - the transmit-burst flag is high through the transmit lead and while transmit activity runs, and low otherwise.
// - the transmit-burst flag rises about 30 us before the transmit burst starts.
// - the transmit-burst flag is driven only in the Cat-M1 radio mode.
// - each indicator is enabled or disabled by its configuration input; disabled ones stay low.
// - the RF-activity flag is high during any transmit or receive activity, low when idle.
// - the RF-activity flag rises at least 0.4 ms and at most 5 ms before activity starts.
module rai_indicators #(
    parameter int RF_LEAD = rai_pkg::RF_LEAD_CYC,
    parameter int TX_LEAD = rai_pkg::TX_LEAD_CYC,
    parameter int REL_DLY = rai_pkg::REL_CYC
) (
    input  wire logic       CLK,
    input  wire logic       ARST_N,
    input  wire logic       TX_REQ,
    input  wire logic       RX_REQ,
    input  wire logic [1:0] RADIO_MODE,
    input  wire logic       TX_IND_EN,
    input  wire logic       RF_IND_EN,
    output logic            TX_BURST_FLAG,
    output logic            RF_ACTIVITY_FLAG,
    output logic            TX_GO,
    output logic            RX_GO
);

    localparam int W = rai_pkg::TMR_W;

    rai_pkg::rai_state_t state_reg;
    rai_pkg::rai_state_t state_next;
    logic                tx_sel_reg;
    logic                tx_sel_next;
    logic                tx_go_next;
    logic                rx_go_next;
    logic                tx_flag_next;
    logic                rf_flag_next;
    logic                tmr_load;
    logic [W-1:0]        tmr_value;
    logic                tmr_done;
    logic                req_sel;

    rai_timer #(.W(W)) u_timer (
        .clk    (CLK),
        .arst_n (ARST_N),
        .load   (tmr_load),
        .value  (tmr_value),
        .done   (tmr_done)
    );

    // request inputs come from the modem scheduler on this clock; no sync needed
    assign req_sel = tx_sel_reg ? TX_REQ : RX_REQ;

    always_comb begin
        state_next  = state_reg;
        tx_sel_next = tx_sel_reg;
        tmr_load    = 1'b0;
        tmr_value   = W'(RF_LEAD);
        unique case (state_reg)
            rai_pkg::RAI_IDLE: begin
                // transmit wins when both arrive together
                if (TX_REQ || RX_REQ) begin
                    state_next  = rai_pkg::RAI_RF_LEAD;
                    tx_sel_next = TX_REQ;
                    tmr_load    = 1'b1;
                    tmr_value   = W'(RF_LEAD);
                end
            end
            rai_pkg::RAI_RF_LEAD: begin
                if (!req_sel) begin
                    state_next = rai_pkg::RAI_IDLE;
                end else if (tmr_done && tx_sel_reg) begin
                    state_next = rai_pkg::RAI_TX_LEAD;
                    tmr_load   = 1'b1;
                    tmr_value  = W'(TX_LEAD);
                end else if (tmr_done) begin
                    state_next = rai_pkg::RAI_ACTIVE;
                end
            end
            rai_pkg::RAI_TX_LEAD: begin
                if (!req_sel) begin
                    state_next = rai_pkg::RAI_IDLE;
                end else if (tmr_done) begin
                    state_next = rai_pkg::RAI_ACTIVE;
                end
            end
            rai_pkg::RAI_ACTIVE: begin
                // hold the rf flag a little past the end so the supply switch settles
                if (!req_sel) begin
                    state_next = rai_pkg::RAI_RELEASE;
                    tmr_load   = 1'b1;
                    tmr_value  = W'(REL_DLY);
                end
            end
            rai_pkg::RAI_RELEASE: begin
                if (tmr_done) begin
                    state_next = rai_pkg::RAI_IDLE;
                end
            end
            default: begin
                state_next = rai_pkg::RAI_IDLE;
            end
        endcase
    end

    // outputs follow the next state so that they line up with state_reg
    always_comb begin
        tx_go_next   = (state_next == rai_pkg::RAI_ACTIVE) && tx_sel_next;
        rx_go_next   = (state_next == rai_pkg::RAI_ACTIVE) && !tx_sel_next;
        tx_flag_next = tx_sel_next && TX_IND_EN
                       && (RADIO_MODE == rai_pkg::RAI_MODE_CATM1)
                       && ((state_next == rai_pkg::RAI_TX_LEAD)
                           || (state_next == rai_pkg::RAI_ACTIVE));
        rf_flag_next = RF_IND_EN && (state_next != rai_pkg::RAI_IDLE);
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_reg        <= rai_pkg::RAI_IDLE;
            tx_sel_reg       <= 1'b0;
            TX_GO            <= 1'b0;
            RX_GO            <= 1'b0;
            TX_BURST_FLAG    <= 1'b0;
            RF_ACTIVITY_FLAG <= 1'b0;
        end else begin
            state_reg        <= state_next;
            tx_sel_reg       <= tx_sel_next;
            TX_GO            <= tx_go_next;
            RX_GO            <= rx_go_next;
            TX_BURST_FLAG    <= tx_flag_next;
            RF_ACTIVITY_FLAG <= rf_flag_next;
        end
    end

    // helper counters: cycles since leaving idle, and since entering the tx lead
    localparam int rf_lo  = RF_LEAD;
    localparam int tx_lo  = TX_LEAD;
    localparam int rel_lo = REL_DLY;
    localparam int rel_hi = rai_pkg::REL_MAX_CYC;
    localparam logic [W-1:0] rf_hi = W'(rai_pkg::RF_LEAD_MAX_CYC);

    logic [W-1:0] act_cnt_reg;
    logic [W-1:0] txl_cnt_reg;
    logic         any_go;

    assign any_go = TX_GO || RX_GO;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            act_cnt_reg <= '0;
            txl_cnt_reg <= '0;
        end else begin
            if (state_reg == rai_pkg::RAI_IDLE) begin
                act_cnt_reg <= '0;
            end else if (act_cnt_reg != '1) begin
                act_cnt_reg <= act_cnt_reg + rai_pkg::TMR_ONE;
            end
            if (state_reg != rai_pkg::RAI_TX_LEAD && state_reg != rai_pkg::RAI_ACTIVE) begin
                txl_cnt_reg <= '0;
            end else if (txl_cnt_reg != '1) begin
                txl_cnt_reg <= txl_cnt_reg + rai_pkg::TMR_ONE;
            end
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    sequence go_fell_s;
        $fell(any_go);
    endsequence

    sequence back_idle_s;
        ##[rel_lo:rel_hi] (state_reg == rai_pkg::RAI_IDLE);
    endsequence

    tx_flag_idle_a: assert property (
        (state_reg == rai_pkg::RAI_IDLE || state_reg == rai_pkg::RAI_RELEASE)
        |-> !TX_BURST_FLAG)
        else $error("tx burst flag high with no transmit");

    tx_lead_time_a: assert property (
        $rose(TX_GO) |-> (txl_cnt_reg >= W'(tx_lo)) && (txl_cnt_reg <= W'(tx_lo + 2)))
        else $error("tx burst lead time wrong");

    tx_mode_gate_a: assert property (
        (RADIO_MODE != rai_pkg::RAI_MODE_CATM1) |=> !TX_BURST_FLAG)
        else $error("tx burst flag outside cat-m1 mode");

    ind_disable_a: assert property (
        !RF_IND_EN |=> !RF_ACTIVITY_FLAG)
        else $error("disabled rf indicator is high");

    rf_flag_act_a: assert property (
        any_go && $past(RF_IND_EN) |-> RF_ACTIVITY_FLAG)
        else $error("rf flag low during activity");

    rf_lead_time_a: assert property (
        $rose(any_go) |-> (act_cnt_reg >= W'(rf_lo)) && (act_cnt_reg <= rf_hi))
        else $error("rf activity lead time out of range");

    rf_release_a: assert property (
        go_fell_s |-> (state_reg == rai_pkg::RAI_RELEASE) and back_idle_s)
        else $error("rf flag release not within bound");

    tx_flag_go_a: assert property (
        TX_GO && $past(TX_IND_EN) && ($past(RADIO_MODE) == rai_pkg::RAI_MODE_CATM1)
        |-> TX_BURST_FLAG)
        else $error("tx burst flag low during transmit");

    tx_ind_disable_a: assert property (
        !TX_IND_EN |=> !TX_BURST_FLAG)
        else $error("disabled tx indicator is high");

    rf_flag_idle_a: assert property (
        (state_reg == rai_pkg::RAI_IDLE) |-> !RF_ACTIVITY_FLAG)
        else $error("rf flag high while idle");

    // a request that drops during either lead must never reach a grant
    lead_abort_a: assert property (
        ((state_reg == rai_pkg::RAI_RF_LEAD) || (state_reg == rai_pkg::RAI_TX_LEAD)) && !req_sel
        |=> (state_reg == rai_pkg::RAI_IDLE) && !any_go)
        else $error("aborted lead still granted activity");

    rf_flag_hold_a: assert property (
        (state_reg == rai_pkg::RAI_RELEASE) && $past(RF_IND_EN) |-> RF_ACTIVITY_FLAG)
        else $error("rf flag dropped before release ended");

endmodule

// [verilog/rai_pkg.sv]
package rai_pkg;

    localparam int CLK_PERIOD_NS = 20;

    // lead and release times in their own units
    localparam int TX_LEAD_NS     = 30000;
    localparam int RF_LEAD_MIN_NS = 400000;
    localparam int RF_LEAD_MAX_NS = 5000000;
    localparam int REL_MIN_NS     = 10000;
    localparam int REL_MAX_NS     = 20000;

    // least times round up, longest times round down
    localparam int TX_LEAD_CYC     = (TX_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RF_LEAD_CYC     = (RF_LEAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RF_LEAD_MAX_CYC = RF_LEAD_MAX_NS / CLK_PERIOD_NS;
    localparam int REL_CYC         = (REL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REL_MAX_CYC     = REL_MAX_NS / CLK_PERIOD_NS;

    localparam int TMR_W = 18;
    localparam logic [TMR_W-1:0] TMR_ZERO = '0;
    localparam logic [TMR_W-1:0] TMR_ONE  = 18'h00001;

    typedef enum logic [1:0] {
        RAI_MODE_CATM1 = 2'h0,
        RAI_MODE_NB    = 2'h1,
        RAI_MODE_GPRS  = 2'h2,
        RAI_MODE_OTHER = 2'h3
    } rai_mode_t;

    // gray along idle -> rf lead -> tx lead -> active -> release
    typedef enum logic [2:0] {
        RAI_IDLE    = 3'h0,
        RAI_RF_LEAD = 3'h1,
        RAI_TX_LEAD = 3'h3,
        RAI_ACTIVE  = 3'h2,
        RAI_RELEASE = 3'h6
    } rai_state_t;

endpackage

// [verilog/rai_timer.sv]
module rai_timer #(
    parameter int W = rai_pkg::TMR_W
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    output logic              done
);

    logic [W-1:0] count_reg;
    logic [W-1:0] count_next;

    always_comb begin
        if (load) begin
            count_next = value;
        end else if (count_reg != W'(0)) begin
            count_next = count_reg - W'(1);
        end else begin
            count_next = count_reg;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign done = (count_reg == W'(0));

endmodule

// [verification/rai_board_switch.sv]
module rai_board_switch (
    input  wire logic rf_activity_flag,
    output logic      rail_from_aux,
    output logic      ant_path_sel
);
    timeunit 1ns;
    timeprecision 1ps;
    // plain wiring: the board follows the flag with no delay of its own
    assign rail_from_aux = rf_activity_flag;
    assign ant_path_sel  = rf_activity_flag;
endmodule

// [verification/rai_indicators_bench.sv]
module rai_indicators_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RFL = 20;
    localparam int TXL = 6;
    localparam int REL = 5;
    logic       clk    = 1'b0;
    logic       arst_n = 1'b0;
    logic       tx_req = 1'b0;
    logic       rx_req = 1'b0;
    logic       tx_en  = 1'b1;
    logic       rf_en  = 1'b1;
    logic [1:0] mode   = 2'h0;
    logic       tx_flag, rf_flag, tx_go, rx_go, rail, ant;
    int         bad_count = 0;
    int         n_checks  = 0;
    int         cyc       = 0;

    always #10 clk = ~clk;

    rai_indicators #(.RF_LEAD(RFL), .TX_LEAD(TXL), .REL_DLY(REL)) u_dut (
        .CLK(clk), .ARST_N(arst_n), .TX_REQ(tx_req), .RX_REQ(rx_req), .RADIO_MODE(mode),
        .TX_IND_EN(tx_en), .RF_IND_EN(rf_en), .TX_BURST_FLAG(tx_flag),
        .RF_ACTIVITY_FLAG(rf_flag), .TX_GO(tx_go), .RX_GO(rx_go)
    );
    rai_board_switch u_board (.rf_activity_flag(rf_flag), .rail_from_aux(rail), .ant_path_sel(ant));

    task automatic tally_and_finish();
        if (bad_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input int exp, input int got);
        n_checks++;
        if (exp != got) begin
            bad_count++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic chk_bits(input string what, input logic [3:0] exp, input logic [3:0] got);
        n_checks++;
        if (exp !== got) begin
            bad_count++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask

    // index 1 is the edge that takes the request or its drop; 0 means never
    task automatic run_case(input logic tx, input logic [1:0] m, input logic ten,
                            input logic ren, input int hold);
        int         rise[4];
        int         fall[4];
        int         e[4];
        logic [3:0] o;
        bit         act;
        bit         lead;
        string      nm[4];
        nm   = '{"rx go", "tx go", "tx flag", "rf flag"};
        rise = '{default: 0};
        fall = '{default: 0};
        // a grant needs the request held through the whole lead, else it is refused
        lead = hold >= RFL + 2;
        act  = tx ? hold >= RFL + TXL + 3 : lead;
        e[3] = ren ? 1 : 0;
        e[2] = (tx && ten && m == 2'h0 && lead) ? RFL + 2 : 0;
        e[1] = (tx && act) ? RFL + TXL + 3 : 0;
        e[0] = (!tx && act) ? RFL + 2 : 0;
        @(posedge clk);
        #2;
        mode   = m;
        tx_en  = ten;
        rf_en  = ren;
        tx_req = tx;
        rx_req = !tx;
        for (int i = 1; i <= hold; i++) begin
            @(posedge clk);
            #1;
            o = {rf_flag, tx_flag, tx_go, rx_go};
            for (int b = 0; b < 4; b++) if (o[b] === 1'b1 && rise[b] == 0) rise[b] = i;
        end
        chk_bits("board switch", {4{rf_flag}}, {rail, ant, rail, ant});
        #1;
        tx_req = 1'b0;
        rx_req = 1'b0;
        for (int j = 1; j <= REL + 4; j++) begin
            @(posedge clk);
            #1;
            o = {rf_flag, tx_flag, tx_go, rx_go};
            for (int b = 0; b < 4; b++) if (o[b] === 1'b0 && fall[b] == 0) fall[b] = j;
        end
        for (int b = 0; b < 4; b++) begin
            chk({nm[b], " rise"}, e[b], rise[b]);
            chk({nm[b], " fall"}, (b == 3 && e[b] != 0 && act) ? REL + 2 : 1, fall[b]);
        end
    endtask

    task automatic tx_burst_case();
        run_case(1'b1, 2'h0, 1'b1, 1'b1, 40);
    endtask

    task automatic rx_case();
        run_case(1'b0, 2'h0, 1'b1, 1'b1, 40);
    endtask

    task automatic mode_case();
        for (int m = 1; m < 4; m++) run_case(1'b1, 2'(m), 1'b1, 1'b1, 40);
    endtask

    task automatic enable_case();
        run_case(1'b1, 2'h0, 1'b0, 1'b1, 40);
        run_case(1'b1, 2'h0, 1'b1, 1'b0, 40);
        run_case(1'b0, 2'h0, 1'b0, 1'b0, 40);
    endtask

    task automatic abort_case();
        run_case(1'b1, 2'h0, 1'b1, 1'b1, 10);
        run_case(1'b1, 2'h0, 1'b1, 1'b1, 25);
        run_case(1'b0, 2'h0, 1'b1, 1'b1, 21);
    endtask

    // reset in the middle of a transmit lead clears every output at once
    task automatic reset_case();
        @(posedge clk);
        #2;
        tx_req = 1'b1;
        repeat (25) @(posedge clk);
        #2;
        arst_n = 1'b0;
        tx_req = 1'b0;
        #1;
        chk_bits("mid reset outputs", 4'h0, {rf_flag, tx_flag, tx_go, rx_go});
        @(posedge clk);
        #2;
        arst_n = 1'b1;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        #1;
        chk_bits("reset outputs", 4'h0, {rf_flag, tx_flag, tx_go, rx_go});
        #1;
        arst_n = 1'b1;
        tx_burst_case();
        rx_case();
        mode_case();
        enable_case();
        abort_case();
        reset_case();
        rx_case();
        tally_and_finish();
    end
endmodule
